// >>> design/csp_ctrl.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
// Behaviour
// RULE_01: Software waits for warm-up end before moving system clock to oscillator.
// RULE_02: Lock flag rises after PLL lock time; software waits before selecting PLL.
// RULE_03: Leave PLL: clock to oscillator, stop PLL, go slow, stop oscillator.
// RULE_04: Before STOP halt with PLL, return to oscillator and stop PLL.
// RULE_05: High oscillator drive bit 0 reduces drive; resets to 1.
// RULE_06: Low oscillator drive bit 0 reduces drive; resets to 1.
// RULE_07: External input bit disables oscillator, forces output pin high; resets 0.
// RULE_08: Protected registers ignore writes while protection is on.
// RULE_09: First key is 0x5A to key register 1, then 0xA5 to 2.
// RULE_10: Second key is 0xA5 to 1, then 0x5A to 2; both toggle protection.
// RULE_11: Protection state is readable in noise control register 0.
// RULE_12: Protection is off after reset.
// RULE_13: Blocked protected write raises the violation interrupt.
// RULE_14: Halt enters idle_partial, idle_oscillator_only or stop by halt mode bits 11, 10, 01.
// RULE_15: Per-port standby drive registers reset to ones, act only in standby.
// RULE_16: Standby buffers follow prior direction and drive bit table.
// RULE_17: Idle_partial stops the CPU; each peripheral runs only if its enable set.
// RULE_18: Idle_oscillator_only keeps only oscillator, real-time clock and melody block running; the code also leaves the PLL running if enabled.
// RULE_19: Stop halts every circuit including the oscillator.
// RULE_20: Software leaves PLL registers alone while running from the slow clock.
// RULE_21: Key writes must be back to back; any other write restarts detection.
module csp_ctrl
    import csp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Standby entry and release
    input wire logic HALT_I,
    input wire logic WAKE_I,
    // Oscillators and clock selection
    output logic HOSC_EN_O,
    output logic HOSC_AMP_EN_O,
    output logic HOSC_DRV_FULL_O,
    output logic LOSC_DRV_FULL_O,
    output logic OSC_OUT_HI_O,
    output logic SYSCLK_LOW_O,
    output logic PLL_ON_O,
    output logic PLL_SEL_O,
    // Protection
    output logic EXT_WE_O,
    output logic PROT_IRQ_O,
    // Run enables
    output logic CPU_RUN_O,
    output logic TMR_RUN_O,
    output logic SIO_RUN_O,
    output logic ADC_RUN_O,
    output logic WDT_RUN_O,
    output logic RTC_RUN_O,
    output logic MLD_RUN_O,
    output logic CORE_RUN_O,
    // Port pins
    input wire logic [8*NPORTS-1:0] PIN_OE_I,
    output logic [8*NPORTS-1:0] PIN_OBUF_EN_O,
    output logic [8*NPORTS-1:0] PIN_IBUF_EN_O
);
    csp_bus_req_t req;
    logic [7:0] sc0, sc1, sc2, pc1, nc0, ie;
    logic pc0_fcsel, warm_done, locked, prot_on;
    logic [7:0] psd [NPORTS];
    logic [11:0] warm_cnt, lock_cnt;
    csp_mode_t mode;
    csp_key_t key_st;
    logic [7:0] next_sc0, next_sc1, next_sc2, next_pc1, next_nc0, next_ie;
    logic next_fcsel, next_warm_done, next_locked, next_prot_on;
    logic [7:0] next_psd [NPORTS];
    logic [11:0] next_warm_cnt, next_lock_cnt;
    csp_mode_t next_mode;
    csp_key_t next_key_st;
    logic [7:0] next_rdata;
    logic prot_hit, blocked, wr_ok, hosc_live, pll_live;

    assign req = '{we: WR_I, re: RD_I, addr: ADDR_I, wdata: WDATA_I};

    always_comb begin
        prot_hit = req.we && (req.addr inside {SYS_CTRL0, SYS_CTRL1,
            SYS_CTRL2, PLL_CTRL0, PLL_CTRL1, NOISE_CTRL0}
            || req.addr[7:6] == EXT_PROT_HI);
        blocked = prot_hit && prot_on; // RULE_08
        wr_ok = req.we && !blocked;
        hosc_live = sc0[SC0_HOSC_EN] && mode != M_STOP; // RULE_19
        pll_live = pc1[PC1_PLLON] && hosc_live;
        next_sc0 = sc0;
        next_sc1 = sc1;
        next_sc2 = sc2;
        next_pc1 = pc1;
        next_nc0 = nc0;
        next_ie = ie;
        next_fcsel = pc0_fcsel;
        next_psd = psd;
        if (wr_ok) begin
            unique case (req.addr)
                SYS_CTRL0: next_sc0 = req.wdata;
                SYS_CTRL1: next_sc1 = req.wdata;
                SYS_CTRL2: next_sc2 = req.wdata;
                PLL_CTRL0: next_fcsel = req.wdata[PC0_FCSEL];
                PLL_CTRL1: next_pc1 = req.wdata;
                NOISE_CTRL0: next_nc0 = req.wdata; // RULE_05 RULE_06 RULE_07
                IDLE_RUN_EN: next_ie = req.wdata;
                PORT_STBY_DRV0: next_psd[0] = req.wdata; // RULE_15
                PORT_STBY_DRV1: next_psd[1] = req.wdata; // RULE_15
                default: ;
            endcase
        end
        // Warm-up restarts whenever the oscillator is stopped, also by STOP
        next_warm_cnt = warm_cnt;
        next_warm_done = warm_done;
        if (!hosc_live) begin
            next_warm_cnt = '0;
            next_warm_done = 1'b0;
        end else if (!warm_done) begin
            next_warm_cnt = warm_cnt + 12'h001;
            next_warm_done = (warm_cnt == WARM_CYC - 12'h001);
        end
        next_lock_cnt = lock_cnt;
        next_locked = locked;
        if (!pll_live) begin
            next_lock_cnt = '0;
            next_locked = 1'b0; // RULE_02
        end else if (!locked) begin
            next_lock_cnt = lock_cnt + 12'h001;
            next_locked = (lock_cnt == LOCK_CYC - 12'h001); // RULE_02
        end
        // Key detection; only the very next write may continue a sequence
        next_key_st = key_st;
        next_prot_on = prot_on;
        if (req.we) begin
            unique case (key_st)
                K_IDLE: next_key_st = (req.addr == KEY_REG1
                    && req.wdata == KEY_A) ? K_FIRST_HALF : K_IDLE; // RULE_09
                K_FIRST_HALF: next_key_st = (req.addr == KEY_REG2
                    && req.wdata == KEY_B) ? K_FIRST_DONE : K_IDLE; // RULE_21
                K_FIRST_DONE: next_key_st = (req.addr == KEY_REG1
                    && req.wdata == KEY_B) ? K_SECOND_HALF : K_IDLE; // RULE_10
                K_SECOND_HALF: begin
                    next_key_st = K_IDLE;
                    if (req.addr == KEY_REG2 && req.wdata == KEY_A) begin
                        next_prot_on = !prot_on; // RULE_10
                    end
                end
                default: next_key_st = K_IDLE;
            endcase
        end
        next_mode = mode;
        unique case (mode)
            M_RUN: if (HALT_I) begin
                unique case (sc2[SC2_HALTM_LSB+:2]) // RULE_14
                    HALT_IDLE_PARTIAL: next_mode = M_IDLE_PARTIAL;
                    HALT_IDLE_OSCILLATOR_ONLY: next_mode = M_IDLE_OSCILLATOR_ONLY;
                    HALT_STOP: next_mode = M_STOP;
                    default: next_mode = M_RUN;
                endcase
            end
            M_IDLE_PARTIAL, M_IDLE_OSCILLATOR_ONLY, M_STOP: if (WAKE_I) begin
                next_mode = M_RUN;
            end
            default: next_mode = M_RUN;
        endcase
        next_rdata = 8'h00;
        if (req.re) begin
            unique case (req.addr)
                SYS_CTRL0: next_rdata = {sc0[7:3], !warm_done, sc0[1:0]};
                SYS_CTRL1: next_rdata = sc1;
                SYS_CTRL2: next_rdata = sc2;
                PLL_CTRL0: next_rdata = {1'b0, pc0_fcsel, locked, 5'h00};
                PLL_CTRL1: next_rdata = pc1;
                NOISE_CTRL0: next_rdata = {nc0[7:6], prot_on,
                    nc0[4:0]}; // RULE_11
                IDLE_RUN_EN: next_rdata = ie;
                PORT_STBY_DRV0: next_rdata = psd[0];
                PORT_STBY_DRV1: next_rdata = psd[1];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            sc0 <= SC0_RST;
            sc1 <= SC1_RST;
            sc2 <= SC2_RST;
            pc0_fcsel <= PC0_RST[PC0_FCSEL];
            pc1 <= PC1_RST;
            nc0 <= NC0_RST; // RULE_05 RULE_06 RULE_07
            ie <= IE_RST;
            for (int i = 0; i < NPORTS; i++) begin
                psd[i] <= PSD_RST; // RULE_15
            end
            warm_cnt <= '0;
            warm_done <= 1'b0;
            lock_cnt <= '0;
            locked <= 1'b0;
            key_st <= K_IDLE;
            prot_on <= 1'b0; // RULE_12
            mode <= M_RUN;
            RDATA_O <= 8'h00;
        end else begin
            sc0 <= next_sc0;
            sc1 <= next_sc1;
            sc2 <= next_sc2;
            pc0_fcsel <= next_fcsel;
            pc1 <= next_pc1;
            nc0 <= next_nc0;
            ie <= next_ie;
            psd <= next_psd;
            warm_cnt <= next_warm_cnt;
            warm_done <= next_warm_done;
            lock_cnt <= next_lock_cnt;
            locked <= next_locked;
            key_st <= next_key_st;
            prot_on <= next_prot_on;
            mode <= next_mode;
            RDATA_O <= next_rdata;
        end
    end

    // Output stage: everything leaves from a flop, one cycle after state
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            HOSC_EN_O <= 1'b0;
            HOSC_AMP_EN_O <= 1'b0;
            HOSC_DRV_FULL_O <= 1'b1;
            LOSC_DRV_FULL_O <= 1'b1;
            OSC_OUT_HI_O <= 1'b0;
            SYSCLK_LOW_O <= 1'b0;
            PLL_ON_O <= 1'b0;
            PLL_SEL_O <= 1'b0;
            EXT_WE_O <= 1'b0;
            PROT_IRQ_O <= 1'b0;
            CPU_RUN_O <= 1'b0;
            TMR_RUN_O <= 1'b0;
            SIO_RUN_O <= 1'b0;
            ADC_RUN_O <= 1'b0;
            WDT_RUN_O <= 1'b0;
            RTC_RUN_O <= 1'b0;
            MLD_RUN_O <= 1'b0;
            CORE_RUN_O <= 1'b0;
        end else begin
            HOSC_EN_O <= hosc_live; // RULE_19
            HOSC_AMP_EN_O <= hosc_live && !nc0[NC0_EXT_IN]; // RULE_07
            HOSC_DRV_FULL_O <= nc0[NC0_HOSC_DRV]; // RULE_05
            LOSC_DRV_FULL_O <= nc0[NC0_LOSC_DRV]; // RULE_06
            OSC_OUT_HI_O <= nc0[NC0_EXT_IN]; // RULE_07
            SYSCLK_LOW_O <= sc1[SC1_SYSCK_LOW];
            PLL_ON_O <= pll_live;
            // Selecting an unlocked PLL would feed a wandering clock
            PLL_SEL_O <= pc0_fcsel && locked; // RULE_02
            EXT_WE_O <= wr_ok && req.addr[7:6] == EXT_PROT_HI; // RULE_08
            PROT_IRQ_O <= blocked; // RULE_13
            CPU_RUN_O <= mode == M_RUN; // RULE_17
            TMR_RUN_O <= mode == M_RUN || mode == M_IDLE_PARTIAL && ie[IE_TMR];
            SIO_RUN_O <= mode == M_RUN || mode == M_IDLE_PARTIAL && ie[IE_SIO];
            ADC_RUN_O <= mode == M_RUN || mode == M_IDLE_PARTIAL && ie[IE_ADC];
            WDT_RUN_O <= mode == M_RUN || mode == M_IDLE_PARTIAL && ie[IE_WDT];
            RTC_RUN_O <= mode != M_STOP; // RULE_18
            MLD_RUN_O <= mode != M_STOP; // RULE_18
            CORE_RUN_O <= mode == M_RUN || mode == M_IDLE_PARTIAL; // RULE_18
        end
    end

    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        csp_pin_buf #(.W(8)) u_pin (
            .clk_i(MCLK_I),
            .rst_i(SYS_RST_I),
            .standby_i(mode != M_RUN), // RULE_15
            .oe_i(PIN_OE_I[8*p+:8]),
            .drive_i(psd[p]),
            .obuf_o(PIN_OBUF_EN_O[8*p+:8]),
            .ibuf_o(PIN_IBUF_EN_O[8*p+:8])
        );
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);

    AST_LOCK_WAIT: assert property (!pll_live |=> !locked ##1 !PLL_SEL_O) // RULE_02
        else $error("PLL selected or locked while stopped");
    AST_HOSC_DRV: assert property (WR_I && ADDR_I == NOISE_CTRL0 && !prot_on
        && !WDATA_I[NC0_HOSC_DRV] |-> ##2 !HOSC_DRV_FULL_O) // RULE_05
        else $error("high oscillator drive not reduced");
    AST_LOSC_DRV: assert property (WR_I && ADDR_I == NOISE_CTRL0 && !prot_on
        && !WDATA_I[NC0_LOSC_DRV] |-> ##2 !LOSC_DRV_FULL_O) // RULE_06
        else $error("low oscillator drive not reduced");
    AST_EXT_IN: assert property (OSC_OUT_HI_O |-> !HOSC_AMP_EN_O) // RULE_07
        else $error("oscillator amplifier on with external input");
    AST_BLOCKED: assert property (WR_I && ADDR_I == SYS_CTRL2 && prot_on
        |=> $stable(sc2) ##0 PROT_IRQ_O) // RULE_08 RULE_13
        else $error("protected write not blocked or not flagged");
    AST_NO_IRQ: assert property (!(prot_hit && prot_on) |=> !PROT_IRQ_O) // RULE_13
        else $error("violation interrupt without blocked write");
    AST_KEYS: assert property (key_st == K_IDLE && WR_I && ADDR_I == KEY_REG1
        && WDATA_I == KEY_A ##1 WR_I && ADDR_I == KEY_REG2 && WDATA_I == KEY_B
        ##1 WR_I && ADDR_I == KEY_REG1 && WDATA_I == KEY_B
        ##1 WR_I && ADDR_I == KEY_REG2 && WDATA_I == KEY_A
        |=> prot_on != $past(prot_on, 4)) // RULE_09 RULE_10 RULE_21
        else $error("double key did not toggle protection");
    AST_PROT_RST: assert property ($past(SYS_RST_I) |-> !prot_on) // RULE_12
        else $error("protection on after reset");
    AST_STATUS: assert property (RD_I && ADDR_I == NOISE_CTRL0
        |=> RDATA_O[NC0_PROTECT] == prot_on) // RULE_11
        else $error("protection status misreported");
    AST_HALT_SEL: assert property (mode == M_RUN && HALT_I
        && sc2[SC2_HALTM_LSB+:2] == HALT_IDLE_OSCILLATOR_ONLY |=> mode == M_IDLE_OSCILLATOR_ONLY) // RULE_14
        else $error("idle_oscillator_only not entered");
    AST_IDLE_PARTIAL: assert property (mode == M_IDLE_PARTIAL |=> !CPU_RUN_O
        && TMR_RUN_O == $past(ie[IE_TMR]) && CORE_RUN_O) // RULE_17
        else $error("idle_partial run enables wrong");
    AST_IDLE_OSCILLATOR_ONLY: assert property (mode == M_IDLE_OSCILLATOR_ONLY |=> !CPU_RUN_O && !CORE_RUN_O
        && !WDT_RUN_O && RTC_RUN_O && MLD_RUN_O) // RULE_18
        else $error("idle_oscillator_only run enables wrong");
    AST_STOP: assert property (mode == M_STOP |=> !HOSC_EN_O
        && !RTC_RUN_O && !MLD_RUN_O) // RULE_19
        else $error("circuits running in stop");
    COV_KEY: cover property (prot_on && !$past(prot_on));
    COV_STOP: cover property (mode == M_STOP ##[1:20] mode == M_RUN);
    COV_IDLE_PARTIAL: cover property (mode == M_IDLE_PARTIAL);
    COV_LOCK: cover property (PLL_SEL_O);
endmodule : csp_ctrl

// >>> design/csp_pkg.sv
package csp_pkg;
    // Register offsets
    localparam logic [7:0] SYS_CTRL0 = 8'h00;
    localparam logic [7:0] SYS_CTRL1 = 8'h01;
    localparam logic [7:0] SYS_CTRL2 = 8'h02;
    localparam logic [7:0] PLL_CTRL0 = 8'h03;
    localparam logic [7:0] PLL_CTRL1 = 8'h04;
    localparam logic [7:0] NOISE_CTRL0 = 8'h05;
    localparam logic [7:0] KEY_REG1 = 8'h06;
    localparam logic [7:0] KEY_REG2 = 8'h07;
    localparam logic [7:0] IDLE_RUN_EN = 8'h08;
    localparam logic [7:0] PORT_STBY_DRV0 = 8'h10;
    localparam logic [7:0] PORT_STBY_DRV1 = 8'h11;
    // Window of protected registers held outside this block
    localparam logic [1:0] EXT_PROT_HI = 2'h1;
    // Field positions
    localparam int SC0_HOSC_EN = 7;
    localparam int SC0_WARMING = 2;
    localparam int SC1_SYSCK_LOW = 0;
    localparam int SC2_HALTM_LSB = 2;
    localparam int PC0_FCSEL = 6;
    localparam int PC0_LOCKED = 5;
    localparam int PC1_PLLON = 7;
    localparam int NC0_HOSC_DRV = 0;
    localparam int NC0_LOSC_DRV = 1;
    localparam int NC0_EXT_IN = 2;
    localparam int NC0_PROTECT = 5;
    localparam int IE_TMR = 0;
    localparam int IE_SIO = 1;
    localparam int IE_ADC = 2;
    localparam int IE_WDT = 3;
    // Reset values
    localparam logic [7:0] SC0_RST = 8'h80;
    localparam logic [7:0] SC1_RST = 8'h00;
    localparam logic [7:0] SC2_RST = 8'h0c;
    localparam logic [7:0] PC0_RST = 8'h00;
    localparam logic [7:0] PC1_RST = 8'h00;
    localparam logic [7:0] NC0_RST = 8'h03;
    localparam logic [7:0] IE_RST = 8'h00;
    localparam logic [7:0] PSD_RST = 8'hff;
    // Key values
    localparam logic [7:0] KEY_A = 8'h5a;
    localparam logic [7:0] KEY_B = 8'ha5;
    // Halt mode codes
    localparam logic [1:0] HALT_IDLE_PARTIAL = 2'b11;
    localparam logic [1:0] HALT_IDLE_OSCILLATOR_ONLY = 2'b10;
    localparam logic [1:0] HALT_STOP = 2'b01;
    // Timing counts in clock cycles
    localparam logic [11:0] WARM_CYC = 12'h100;
    localparam logic [11:0] LOCK_CYC = 12'h080;
    localparam int NPORTS = 2;

    typedef enum logic [3:0] {
        M_RUN = 4'b0001,
        M_IDLE_PARTIAL = 4'b0010,
        M_IDLE_OSCILLATOR_ONLY = 4'b0100,
        M_STOP = 4'b1000
    } csp_mode_t;

    typedef enum logic [3:0] {
        K_IDLE = 4'b0001,
        K_FIRST_HALF = 4'b0010,
        K_FIRST_DONE = 4'b0100,
        K_SECOND_HALF = 4'b1000
    } csp_key_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csp_bus_req_t;
endpackage : csp_pkg

// >>> design/csp_pin_buf.sv
`timescale 1ns/100ps
module csp_pin_buf #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] drive_i,
    output logic [W-1:0] obuf_o,
    output logic [W-1:0] ibuf_o
);
    logic [W-1:0] oe_prior;
    logic [W-1:0] next_oe_prior;
    logic [W-1:0] next_obuf;
    logic [W-1:0] next_ibuf;

    always_comb begin
        // Direction is frozen at halt entry; later changes must not leak
        next_oe_prior = standby_i ? oe_prior : oe_i;
        if (standby_i) begin
            next_obuf = oe_prior & drive_i; // RULE_16
            next_ibuf = ~oe_prior & drive_i; // RULE_16
        end else begin
            next_obuf = oe_i; // RULE_15
            next_ibuf = ~oe_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_prior <= '0;
            obuf_o <= '0;
            ibuf_o <= '0;
        end else begin
            oe_prior <= next_oe_prior;
            obuf_o <= next_obuf;
            ibuf_o <= next_ibuf;
        end
    end

    AST_PIN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_i && $stable(standby_i) |=> (obuf_o & ibuf_o) == '0
                                          && (obuf_o & ~$past(drive_i)) == '0) // RULE_16
        else $error("standby pin buffers on without drive bit");
endmodule : csp_pin_buf

// >>> verif/csp_ctrl_test.sv
`timescale 1ns/100ps
module csp_ctrl_test;
    import csp_pkg::*;
    logic clk, rst, wr_s, rd_s, halt, wake;
    logic [7:0] addr, wdata, rdata, d;
    logic hosc_en, amp, hdrv, ldrv, osc_hi, sys_low, pll_on, pll_sel;
    logic ext_we, irq, cpu, tmr, sio, adc, wdt, rtc, melody_block, core;
    logic [8*NPORTS-1:0] pin_oe, obuf, ibuf, oe, drv;
    logic [7:0] mdl [256] = '{default: 8'h00};
    logic [7:0] rmap [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h20};
    logic [1:0] modes [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    logic [63:0] hist = 64'h0;
    logic [8:0] rv;
    logic [7:0] ie;
    logic prot = 1'b0;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int irqs = 0;
    int ext_wes = 0;
    int exp_irq = 0;
    int exp_ext = 0;

    csp_ctrl csp_ctrl_i (
        .MCLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .HALT_I(halt),
        .WAKE_I(wake), .HOSC_EN_O(hosc_en), .HOSC_AMP_EN_O(amp),
        .HOSC_DRV_FULL_O(hdrv), .LOSC_DRV_FULL_O(ldrv),
        .OSC_OUT_HI_O(osc_hi), .SYSCLK_LOW_O(sys_low), .PLL_ON_O(pll_on),
        .PLL_SEL_O(pll_sel), .EXT_WE_O(ext_we), .PROT_IRQ_O(irq),
        .CPU_RUN_O(cpu), .TMR_RUN_O(tmr), .SIO_RUN_O(sio), .ADC_RUN_O(adc),
        .WDT_RUN_O(wdt), .RTC_RUN_O(rtc), .MLD_RUN_O(melody_block),
        .CORE_RUN_O(core), .PIN_OE_I(pin_oe), .PIN_OBUF_EN_O(obuf),
        .PIN_IBUF_EN_O(ibuf)
    );

    task automatic close_out;
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Model of the register file, key detector and protected window
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic blocked;
        logic ext;
        ext = (a >= 8'h40 && a <= 8'h7f);
        blocked = prot && (a <= NOISE_CTRL0 || ext);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_s <= 1'b0;
        if (blocked) exp_irq++;
        if (!blocked && ext) exp_ext++;
        if (!blocked && (a <= IDLE_RUN_EN || a == PORT_STBY_DRV0 ||
                a == PORT_STBY_DRV1) && a != KEY_REG1 && a != KEY_REG2) begin
            mdl[a] = v;
        end
        hist = {hist[47:0], a, v};
        if (hist == {KEY_REG1, KEY_A, KEY_REG2, KEY_B,
                KEY_REG1, KEY_B, KEY_REG2, KEY_A}) begin
            prot = !prot;
            hist = 64'h0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] e;
        e = mdl[a];
        if (a == NOISE_CTRL0) e = {e[7:6], prot, e[4:0]};
        rd(a);
        chk(d & m, e & m);
    endtask : rdc

    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
        end while (d[b] !== v && n < 300);
        chk(16'(n < 300), 16'h1);
    endtask : poll

    // A read between the halves is allowed; a write restarts detection
    task automatic key(input logic [1:0] brk);
        if (brk == 2'd2) begin
            // All four key writes back to back, strobe held high throughout
            @(posedge clk);
            wr_s <= 1'b1;
            {addr, wdata} <= {KEY_REG1, KEY_A};
            @(posedge clk);
            {addr, wdata} <= {KEY_REG2, KEY_B};
            @(posedge clk);
            {addr, wdata} <= {KEY_REG1, KEY_B};
            @(posedge clk);
            {addr, wdata} <= {KEY_REG2, KEY_A};
            @(posedge clk);
            wr_s <= 1'b0;
            prot = !prot;
            hist = 64'h0;
        end else begin
            wr(KEY_REG1, KEY_A);
            wr(KEY_REG2, KEY_B);
            if (brk[0]) wr(IDLE_RUN_EN, mdl[IDLE_RUN_EN]);
            else rd(KEY_REG1);
            wr(KEY_REG1, KEY_B);
            wr(KEY_REG2, KEY_A);
        end
    endtask : key

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (ext_we === 1'b1) ext_wes++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        rst = 1'b1;
        {wr_s, rd_s, halt, wake} = 4'h0;
        {addr, wdata} = 16'h0;
        pin_oe = '0;
        void'($urandom(17));
        {mdl[0], mdl[1], mdl[2], mdl[3]} = {SC0_RST, SC1_RST, SC2_RST, PC0_RST};
        {mdl[4], mdl[5], mdl[8]} = {PC1_RST, NC0_RST, IE_RST};
        {mdl[16], mdl[17]} = {PSD_RST, PSD_RST};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rmap[i]) rdc(rmap[i], (i == 0) ? 8'hfb : 8'hff);
        chk({hdrv, ldrv, osc_hi, amp, hosc_en}, 5'b11011);
        foreach (rmap[i]) begin
            if (i < 5) begin
                wr(NOISE_CTRL0, {5'h0, 3'(i == 4 ? 3 : (i == 3 ? 4 : i))});
                settle();
                d = mdl[NOISE_CTRL0];
                chk({hdrv, ldrv, osc_hi, amp}, {d[0], d[1], d[2], ~d[2]});
            end
        end
        wr(SYS_CTRL1, 8'h01);
        settle();
        chk(sys_low, 1'b1);
        poll(SYS_CTRL0, SC0_WARMING, 1'b0);
        wr(SYS_CTRL1, 8'h00);
        wr(PLL_CTRL1, 8'h80);
        rd(PLL_CTRL0);
        chk(d[PC0_LOCKED], 1'b0);
        poll(PLL_CTRL0, PC0_LOCKED, 1'b1);
        wr(PLL_CTRL0, 8'h40);
        settle();
        chk({pll_on, pll_sel, sys_low}, 3'b110);
        wr(PLL_CTRL0, 8'h00);
        wr(PLL_CTRL1, 8'h00);
        settle();
        chk({pll_on, pll_sel}, 2'b00);
        key(2'd2);
        rdc(NOISE_CTRL0, 8'hff);
        wr(NOISE_CTRL0, 8'h00);
        wr(SYS_CTRL2, 8'h04);
        wr(8'h40, 8'h11);
        wr(IDLE_RUN_EN, 8'h05);
        settle();
        chk(16'(irqs), 16'(exp_irq));
        chk(16'(ext_wes), 16'(exp_ext));
        chk(hdrv, 1'b1);
        rdc(NOISE_CTRL0, 8'hff);
        rdc(SYS_CTRL2, 8'hff);
        rdc(IDLE_RUN_EN, 8'hff);
        key(2'd1);
        rdc(NOISE_CTRL0, 8'hff);
        key(2'd0);
        wr(8'h41, 8'h22);
        wr(NOISE_CTRL0, 8'h03);
        settle();
        chk(16'(irqs), 16'(exp_irq));
        chk(16'(ext_wes), 16'(exp_ext));
        rdc(NOISE_CTRL0, 8'hff);
        foreach (modes[m]) begin
            wr(SYS_CTRL2, {4'h0, modes[m], 2'b00});
            wr(IDLE_RUN_EN, 8'($urandom_range(15)));
            wr(PORT_STBY_DRV0, 8'($urandom));
            wr(PORT_STBY_DRV1, 8'($urandom));
            oe = 16'($urandom);
            pin_oe <= oe;
            settle();
            chk(obuf ^ ibuf, 16'hffff);
            chk(obuf, oe);
            @(posedge clk);
            halt <= 1'b1;
            @(posedge clk);
            halt <= 1'b0;
            repeat (2) @(posedge clk);
            pin_oe <= ~oe;
            settle();
            drv = {mdl[PORT_STBY_DRV1], mdl[PORT_STBY_DRV0]};
            ie = mdl[IDLE_RUN_EN];
            case (modes[m])
                HALT_IDLE_PARTIAL: rv = {1'b0, ie[0], ie[1], ie[2], ie[3], 4'hf};
                HALT_IDLE_OSCILLATOR_ONLY: rv = 9'b000001101;
                HALT_STOP: rv = 9'h000;
                default: rv = 9'h1ff;
            endcase
            chk({cpu, tmr, sio, adc, wdt, rtc, melody_block, core, hosc_en}, rv);
            if (modes[m] == 2'b00) oe = ~oe;
            if (modes[m] == 2'b00) drv = 16'hffff;
            chk(obuf, oe & drv);
            chk(ibuf, ~oe & drv);
            @(posedge clk);
            wake <= 1'b1;
            @(posedge clk);
            wake <= 1'b0;
            settle();
            chk({cpu, core}, 2'b11);
        end
        close_out();
    end
endmodule : csp_ctrl_test
